// ### design/cbti_host.sv
`timescale 1ns/1ps
`default_nettype none
module cbti_host #(
	parameter int NUM_BUF       = 16,
	parameter int PCLK_OVER_OSC = 1
) (
	input  wire logic                       CLK_SYS,
	input  wire logic                       SYS_RST,
	input  wire logic                       CE,
	input  wire logic                       LOW_POWER,
	input  wire logic                       WB_CYC_I,
	input  wire logic                       WB_STB_I,
	input  wire logic                       WB_WE_I,
	input  wire logic [cbti_pkg::WB_AW-1:0] WB_ADR_I,
	input  wire logic [31:0]                WB_DAT_I,
	input  wire logic [3:0]                 WB_SEL_I,
	output logic      [31:0]                WB_DAT_O,
	output logic                            WB_ACK_O,
	output logic                            DEV_REQ,
	output logic                            DEV_WE,
	output logic      [cbti_pkg::DEV_AW-1:0] DEV_ADDR,
	output logic      [31:0]                DEV_WDATA,
	input  wire logic [31:0]                DEV_RDATA,
	input  wire logic                       DEV_ACK
);
	import cbti_pkg::*;

	// only 32 mask and activity bits exist, one per buffer
	if (NUM_BUF < 1 || NUM_BUF > 32) begin : g_bad_buf
		$error("NUM_BUF must lie in 1..32");
	end
	// [R11] peripheral not slower
	if (PCLK_OVER_OSC < 1) begin : g_bad_ratio
		$error("PCLK_OVER_OSC must be at least 1");
	end

	cbti_cfg_if cfg ();
	cbti_check #(
		.PCLK_OVER_OSC(PCLK_OVER_OSC)
	) u_check (
		.cfg(cfg)
	);

	cbti_state_t state;
	cbti_state_t next_state;
	cbti_acc_t   acc;
	logic [31:0] timing;
	logic [31:0] buffer_interrupt_mask;
	logic [31:0] bact;
	logic [5:0]  mb_idx;
	logic [5:0]  flt;
	logic        wb_req;
	logic        idle;
	logic        go;
	logic        srst_go;
	logic        dev_dis;
	logic        frz_seen;
	logic        last_csrc;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i])
				r[8*i+:8] = nw[8*i+:8];
		end
		return r;
	endfunction : merge

	function automatic logic [31:0] mcr_word(input logic dis,
		input logic halt);
		logic [31:0] w;
		w = '0;
		w[MCR_MODULE_DISABLE] = dis;
		w[MCR_FRZ]  = 1'b1;
		w[MCR_HALT] = halt;
		return w;
	endfunction : mcr_word

	assign cfg.timing = timing;
	assign wb_req  = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign idle    = state == S_IDLE || state == S_DONE || state == S_FAIL;
	assign go      = wb_req && WB_WE_I && WB_ADR_I == CMD_OFF && WB_SEL_I[0]
		&& WB_DAT_I[CMD_START] && idle;
	assign srst_go = WB_DAT_I[CMD_SRST];

	// wishbone slave, answers one cycle after the strobe
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= '0;
		end else if (CE) begin
			WB_ACK_O <= wb_req;
			if (wb_req && !WB_WE_I) begin
				unique case (WB_ADR_I)
					TIM_OFF:  WB_DAT_O <= timing;
					MASK_OFF: WB_DAT_O <= buffer_interrupt_mask;
					BACT_OFF: WB_DAT_O <= bact;
					STAT_OFF: WB_DAT_O <= {11'h000, 1'b0, 4'(state),
						2'h0, flt, 5'h00, state == S_FAIL,
						state == S_DONE, !idle};
					default:  WB_DAT_O <= '0;
				endcase
			end
		end
	end

	// settings are locked while a sequence runs
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			timing <= TIM_RST;
			buffer_interrupt_mask  <= MASK_RST;
			bact   <= BACT_RST;
		end else if (CE && wb_req && WB_WE_I && idle) begin
			if (WB_ADR_I == TIM_OFF)
				timing <= merge(timing, WB_DAT_I, WB_SEL_I);
			if (WB_ADR_I == MASK_OFF)
				buffer_interrupt_mask <= merge(buffer_interrupt_mask, WB_DAT_I, WB_SEL_I);
			if (WB_ADR_I == BACT_OFF)
				bact <= merge(bact, WB_DAT_I, WB_SEL_I);
		end
	end

	always_comb begin
		acc.addr   = DEV_MCR_OFF;
		acc.we     = 1'b1;
		acc.data   = '0;
		next_state = state;
		unique case (state)
			S_SRST_W: begin
				acc.data[MCR_SRST] = 1'b1;
				next_state = S_SRST_P;
			end
			// [R15] poll until reset done
			S_SRST_P: begin
				acc.we = 1'b0;
				next_state = DEV_RDATA[MCR_SRST] ? S_SRST_P : S_DIS_W;
			end
			S_DIS_W: begin
				acc.data = mcr_word(1'b1, 1'b1);
				next_state = S_CSRC_W;
			end
			// [R2] source while disabled
			S_CSRC_W: begin
				acc.addr = DEV_CTRL_OFF;
				acc.data[CTRL_CSRC] = timing[CTRL_CSRC];
				next_state = S_EN_W;
			end
			// [R17] enable enters freeze
			S_EN_W: begin
				acc.data = mcr_word(1'b0, 1'b1);
				next_state = S_FRZ_P;
			end
			// [R20] wait for freeze
			S_FRZ_P: begin
				acc.we = 1'b0;
				next_state = DEV_RDATA[MCR_FACK] ? S_TIM_W : S_FRZ_P;
			end
			// [R21] timing and arbitration mode
			S_TIM_W: begin
				acc.addr = DEV_CTRL_OFF;
				acc.data = timing;
				next_state = S_MB_W;
			end
			// [R19] buffers need explicit init
			S_MB_W: begin
				acc.addr = DEV_MB_BASE + (DEV_AW'(mb_idx) << MB_SHIFT);
				acc.data[MB_CODE_LSB+:4] =
					bact[5'(mb_idx)] ? MB_RX_EMPTY : MB_INACTIVE;
				next_state = (mb_idx == 6'(NUM_BUF - 1)) ? S_MASK_W : S_MB_W;
			end
			S_MASK_W: begin
				acc.addr = DEV_BUFFER_INTERRUPT_MASK_OFF;
				for (int i = 0; i < 32; i++)
					acc.data[i] = buffer_interrupt_mask[i] && i < NUM_BUF;
				next_state = S_RUN_W;
			end
			// [R22] clear halt to run
			S_RUN_W: begin
				acc.data = mcr_word(1'b0, 1'b0);
				next_state = S_RUN_P;
			end
			S_RUN_P: begin
				acc.we = 1'b0;
				next_state = (DEV_RDATA[MCR_FACK] || DEV_RDATA[MCR_NRDY])
					? S_RUN_P : S_DONE;
			end
			S_IDLE, S_DONE, S_FAIL: begin
			end
			default: next_state = S_IDLE;
		endcase
	end

	// sequencer and device port; one idle cycle between accesses
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			state     <= S_IDLE;
			DEV_REQ   <= 1'b0;
			DEV_WE    <= 1'b0;
			DEV_ADDR  <= '0;
			DEV_WDATA <= '0;
			mb_idx    <= '0;
			flt       <= '0;
		end else if (CE) begin
			if (idle) begin
				if (go) begin
					mb_idx <= '0;
					// [R16] no reset in low power
					flt <= {srst_go && LOW_POWER, cfg.fault};
					if (|cfg.fault || (srst_go && LOW_POWER))
						state <= S_FAIL;
					else
						state <= srst_go ? S_SRST_W : S_DIS_W;
				end
			end else if (!DEV_REQ) begin
				DEV_REQ   <= 1'b1;
				DEV_WE    <= acc.we;
				DEV_ADDR  <= acc.addr;
				DEV_WDATA <= acc.data;
			end else if (DEV_ACK) begin
				DEV_REQ <= 1'b0;
				state   <= next_state;
				if (state == S_MB_W)
					mb_idx <= mb_idx + 6'h01;
			end
		end
	end

	// shadows of device mode, used only by the checks below
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			dev_dis   <= 1'b0;
			frz_seen  <= 1'b0;
			last_csrc <= 1'b0;
		end else if (CE && DEV_REQ && DEV_ACK) begin
			if (DEV_WE && DEV_ADDR == DEV_MCR_OFF) begin
				dev_dis <= DEV_WDATA[MCR_MODULE_DISABLE];
				if (!DEV_WDATA[MCR_HALT] || DEV_WDATA[MCR_MODULE_DISABLE])
					frz_seen <= 1'b0;
			end
			if (!DEV_WE && DEV_ADDR == DEV_MCR_OFF && DEV_RDATA[MCR_FACK])
				frz_seen <= 1'b1;
			if (DEV_WE && DEV_ADDR == DEV_CTRL_OFF)
				last_csrc <= DEV_WDATA[CTRL_CSRC];
		end
	end

	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (SYS_RST);

	csrc_change_a: // [R2]
	assert property (DEV_REQ && DEV_WE && DEV_ADDR == DEV_CTRL_OFF
		&& DEV_WDATA[CTRL_CSRC] != last_csrc |-> dev_dis)
		else $error("clock source changed while device enabled");

	seg1_len_a: // [R5]
	assert property (DEV_REQ && state == S_TIM_W
		|-> cbti_seg1(DEV_WDATA) >= 5'(SEG1_MIN)
		&& cbti_seg1(DEV_WDATA) <= 5'(SEG1_MAX))
		else $error("segment one out of range");

	seg2_len_a: // [R6]
	assert property (DEV_REQ && state == S_TIM_W
		|-> cbti_seg2(DEV_WDATA) >= 4'(SEG2_MIN)
		&& cbti_seg2(DEV_WDATA) <= 4'(SEG2_MAX))
		else $error("segment two out of range");

	std_table_a: // [R9]
	assert property (DEV_REQ && state == S_TIM_W |-> cbti_std_ok(DEV_WDATA))
		else $error("timing not standard compliant");

	min_quanta_a: // [R10]
	assert property (DEV_REQ && state == S_TIM_W
		|-> cbti_nq(DEV_WDATA) >= 6'(MIN_TQ))
		else $error("fewer than eight quanta per bit");

	clock_ratio_a: // [R12]
	assert property (DEV_REQ && state == S_TIM_W
		|-> cbti_ratio(DEV_WDATA, PCLK_OVER_OSC) >= 32'(MIN_RATIO))
		else $error("clock to bit rate ratio too low");

	lp_refuse_a: // [R16]
	assert property (CE && go && srst_go && LOW_POWER
		|=> state == S_FAIL && flt[F_LP] && !DEV_REQ)
		else $error("soft reset started in low power");

	frz_first_a: // [R20]
	assert property (DEV_REQ && DEV_WE && state inside {S_TIM_W, S_MB_W,
		S_MASK_W} |-> frz_seen && !dev_dis)
		else $error("configuration outside freeze");

	init_order_a: // [R21]
	assert property (state == S_RUN_W && $past(state, 1) != S_RUN_W
		|-> $past(state, 1) == S_MASK_W && mb_idx == 6'(NUM_BUF))
		else $error("halt cleared before buffers were set");

	leave_frz_a: // [R22]
	assert property (CE && DEV_REQ && DEV_ACK && state == S_RUN_P
		&& !DEV_RDATA[MCR_FACK] && !DEV_RDATA[MCR_NRDY]
		|=> state == S_DONE ##1 !DEV_REQ [*2])
		else $error("run not reported after freeze left");
endmodule : cbti_host
`default_nettype wire

// ### inc/cbti_pkg.sv
// Function
// [R1] One bit picks bus clock or crystal for the protocol engine.
// [R2] Clock-source bit is changed only while the device is disabled.
// [R3] Quantum clock is the selected clock divided by prescale plus one.
// [R4] Bit opens with a one-quantum sync; rate is quanta rate over quanta.
// [R5] Segment 1 is propagation plus phase one plus 2, kept within 4 to 16.
// [R6] Segment 2 is phase two plus 1, kept within 2 to 8.
// [R7] New bit leaves at transmit point; sample point is third of three.
// [R8] Device uses an information processing time of 2 quanta.
// [R9] Segment 1 range per segment 2; jump width 1 to min of 4 and segment 2.
// [R10] At least 8 quanta per bit.
// [R11] Peripheral clock is never slower than the oscillator clock.
// [R12] Peripheral clock is at least 16 times the bit rate.
// [R13] Device scans all message buffers within the frame's time window.
// [R14] Hard reset clears registers async; soft reset a subset, synchronously.
// [R15] Soft-reset bit reads set until the reset has completed.
// [R16] No soft reset while clocks are stopped in low power.
// [R17] Clearing module disable puts the device into freeze by itself.
// [R18] Freeze sets halt, freeze, ack, not-ready; transmit stays recessive.
// [R19] No reset touches message buffer contents.
// [R20] Configuration is done only in freeze mode.
// [R21] Init writes timing, prescale, arbitration mode, buffers, masks.
// [R22] Clearing halt makes the device leave freeze and synchronise.
// [R23] Device counts quanta through segments; resync bounded by jump width.
`default_nettype none
package cbti_pkg;
	localparam int WB_AW  = 8;
	localparam int DEV_AW = 12;
	// own register map, byte addresses
	localparam logic [7:0] CMD_OFF  = 8'h00;
	localparam logic [7:0] TIM_OFF  = 8'h04;
	localparam logic [7:0] MASK_OFF = 8'h08;
	localparam logic [7:0] BACT_OFF = 8'h0c;
	localparam logic [7:0] STAT_OFF = 8'h10;
	localparam logic [31:0] TIM_RST  = 32'h00000000;
	localparam logic [31:0] MASK_RST = 32'h00000000;
	localparam logic [31:0] BACT_RST = 32'h00000000;
	localparam int CMD_START    = 0;
	localparam int CMD_SRST     = 1;
	localparam int ST_BUSY      = 0;
	localparam int ST_DONE      = 1;
	localparam int ST_FAIL      = 2;
	localparam int ST_FLT_LSB   = 8;
	localparam int ST_STATE_LSB = 16;
	localparam int F_SEG1  = 0;
	localparam int F_SEG2  = 1;
	localparam int F_STD   = 2;
	localparam int F_NQ    = 3;
	localparam int F_RATIO = 4;
	localparam int F_LP    = 5;
	// device map
	localparam logic [11:0] DEV_MCR_OFF   = 12'h000;
	localparam logic [11:0] DEV_CTRL_OFF  = 12'h004;
	localparam logic [11:0] DEV_BUFFER_INTERRUPT_MASK_OFF = 12'h028;
	localparam logic [11:0] DEV_MB_BASE   = 12'h080;
	localparam int MB_SHIFT = 4;
	localparam int MCR_MODULE_DISABLE = 31;
	localparam int MCR_FRZ  = 30;
	localparam int MCR_HALT = 28;
	localparam int MCR_NRDY = 27;
	localparam int MCR_SRST = 25;
	localparam int MCR_FACK = 24;
	localparam int CTRL_PRES = 24;
	localparam int CTRL_RJW  = 22;
	localparam int CTRL_P1   = 19;
	localparam int CTRL_P2   = 16;
	localparam int CTRL_CSRC = 13;
	localparam int CTRL_LOWEST_BUFFER_FIRST = 4;
	localparam int CTRL_PROP = 0;
	localparam int MB_CODE_LSB = 24;
	localparam logic [3:0] MB_INACTIVE = 4'h0;
	localparam logic [3:0] MB_RX_EMPTY = 4'h4;
	// timing limits
	localparam int SEG1_ADD  = 2;
	localparam int SEG2_ADD  = 1;
	localparam int SEG1_MIN  = 4;
	localparam int SEG1_MAX  = 16;
	localparam int SEG2_MIN  = 2;
	localparam int SEG2_MAX  = 8;
	localparam int SEG1_SPAN = 8;
	localparam int RJW_MAX   = 4;
	localparam int MIN_TQ    = 8;
	localparam int MIN_RATIO = 16;
	typedef enum logic [3:0] {
		S_IDLE   = 4'b0000,
		S_SRST_W = 4'b0001,
		S_SRST_P = 4'b0010,
		S_DIS_W  = 4'b0011,
		S_CSRC_W = 4'b0100,
		S_EN_W   = 4'b0101,
		S_FRZ_P  = 4'b0110,
		S_TIM_W  = 4'b0111,
		S_MB_W   = 4'b1000,
		S_MASK_W = 4'b1001,
		S_RUN_W  = 4'b1010,
		S_RUN_P  = 4'b1011,
		S_DONE   = 4'b1100,
		S_FAIL   = 4'b1101
	} cbti_state_t;
	typedef struct packed {
		logic [11:0] addr;
		logic        we;
		logic [31:0] data;
	} cbti_acc_t;
	function automatic logic [4:0] cbti_seg1(input logic [31:0] t);
		return 5'(t[CTRL_PROP+:3]) + 5'(t[CTRL_P1+:3]) + 5'(SEG1_ADD);
	endfunction : cbti_seg1
	function automatic logic [3:0] cbti_seg2(input logic [31:0] t);
		return 4'(t[CTRL_P2+:3]) + 4'(SEG2_ADD);
	endfunction : cbti_seg2
	function automatic logic [5:0] cbti_nq(input logic [31:0] t);
		return 6'd1 + 6'(cbti_seg1(t)) + 6'(cbti_seg2(t));
	endfunction : cbti_nq
	function automatic logic [4:0] cbti_s1min(input logic [3:0] s2);
		return (s2 == 4'h2) ? 5'h05 : (s2 == 4'h3) ? 5'h04 : 5'(s2) + 5'h01;
	endfunction : cbti_s1min
	function automatic logic cbti_std_ok(input logic [31:0] t);
		logic [4:0] s1;
		logic [3:0] s2;
		logic [2:0] rj;
		s1 = cbti_seg1(t);
		s2 = cbti_seg2(t);
		rj = 3'(t[CTRL_RJW+:2]) + 3'h1;
		return s1 >= cbti_s1min(s2) && s1 <= 5'(s2) + 5'(SEG1_SPAN)
			&& 4'(rj) <= s2 && rj <= 3'(RJW_MAX);
	endfunction : cbti_std_ok
	function automatic logic [31:0] cbti_ratio(input logic [31:0] t,
		input int pclk_over_osc);
		logic [31:0] r;
		r = (32'(t[CTRL_PRES+:8]) + 32'h1) * 32'(cbti_nq(t));
		if (t[CTRL_CSRC])
			r = r * 32'(pclk_over_osc);
		return r;
	endfunction : cbti_ratio
endpackage : cbti_pkg
`default_nettype wire

// ### inc/cbti_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cbti_cfg_if;
	logic [31:0] timing;
	logic [4:0]  fault;
	modport seq  (output timing, input fault);
	modport calc (input timing, output fault);
endinterface : cbti_cfg_if
`default_nettype wire

// ### design/cbti_check.sv
`timescale 1ns/1ps
`default_nettype none
module cbti_check #(
	parameter int PCLK_OVER_OSC = 1
) (
	cbti_cfg_if.calc cfg
);
	import cbti_pkg::*;
	logic [4:0] seg1;
	logic [3:0] seg2;
	always_comb begin
		seg1 = cbti_seg1(cfg.timing);
		seg2 = cbti_seg2(cfg.timing);
		// [R5] segment one range
		cfg.fault[F_SEG1] = seg1 < 5'(SEG1_MIN) || seg1 > 5'(SEG1_MAX);
		// [R6] segment two range
		cfg.fault[F_SEG2] = seg2 < 4'(SEG2_MIN) || seg2 > 4'(SEG2_MAX);
		// [R9] standard table check
		cfg.fault[F_STD] = !cbti_std_ok(cfg.timing);
		// [R10] quanta per bit
		cfg.fault[F_NQ] = cbti_nq(cfg.timing) < 6'(MIN_TQ);
		// [R12] clock to bit-rate ratio
		cfg.fault[F_RATIO] =
			cbti_ratio(cfg.timing, PCLK_OVER_OSC) < 32'(MIN_RATIO);
	end
endmodule : cbti_check
`default_nettype wire

// ### tb/cbti_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module cbti_dev_model #(
	parameter int NUM_BUF = 4
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        req,
	input  wire logic        we,
	input  wire logic [11:0] addr,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  dly,
	output logic             ack,
	output logic      [31:0] rdata
);
	import cbti_pkg::*;
	logic [31:0] mcr, ctrl, buffer_interrupt_mask;
	logic [3:0]  code [NUM_BUF];
	logic [3:0]  cnt, srst_cnt, run_cnt;
	int          n_acc, n_bad;
	logic        dis, freeze_enable;
	assign dis = mcr[MCR_MODULE_DISABLE];
	assign freeze_enable = mcr[MCR_FACK];
	always @(posedge clk) begin
		if (rst) begin
			{mcr, ctrl, buffer_interrupt_mask, rdata} <= '0;
			{ack, cnt, srst_cnt, run_cnt} <= '0;
			n_acc <= 0;
			n_bad <= 0;
		end else begin
			// released bus shows a moving pattern, not the last word
			rdata <= ~rdata;
			if (srst_cnt == 4'h1) begin
				mcr[MCR_SRST] <= 1'b0;
				ctrl <= '0;
				buffer_interrupt_mask <= '0;
			end
			if (srst_cnt != 4'h0) srst_cnt <= srst_cnt - 4'h1;
			if (run_cnt == 4'h1) {mcr[MCR_FACK], mcr[MCR_NRDY]} <= 2'b00;
			if (run_cnt != 4'h0) run_cnt <= run_cnt - 4'h1;
			if (ack) ack <= 1'b0;
			else if (req && cnt < dly) cnt <= cnt + 4'h1;
			else if (req) begin
				ack <= 1'b1;
				cnt <= 4'h0;
				n_acc <= n_acc + 1;
				rdata <= addr == DEV_MCR_OFF ? mcr : addr == DEV_CTRL_OFF ? ctrl
					: addr == DEV_BUFFER_INTERRUPT_MASK_OFF ? buffer_interrupt_mask : 32'h0;
				if (we && addr == DEV_MCR_OFF) begin
					mcr[MCR_MODULE_DISABLE] <= wdata[MCR_MODULE_DISABLE];
					mcr[MCR_FRZ] <= wdata[MCR_FRZ];
					mcr[MCR_HALT] <= wdata[MCR_HALT];
					// enabling drops into freeze
					// bit 31 is left to the enable write above
					if (dis && !wdata[MCR_MODULE_DISABLE])
						mcr[30:24] <= mcr[30:24] | 7'h59;
					if (freeze_enable && !wdata[MCR_HALT]) run_cnt <= 4'h3;
					if (wdata[MCR_SRST]) begin
						mcr[MCR_SRST] <= 1'b1;
						srst_cnt <= 4'h5;
					end
				end
				if (we && addr == DEV_CTRL_OFF) begin
					ctrl <= wdata;
					n_bad <= n_bad + int'(!dis && !freeze_enable)
						+ int'(!dis && wdata[CTRL_CSRC] !== ctrl[CTRL_CSRC]);
				end
				if (we && (addr == DEV_BUFFER_INTERRUPT_MASK_OFF || addr >= DEV_MB_BASE)) begin
					if (addr == DEV_BUFFER_INTERRUPT_MASK_OFF) buffer_interrupt_mask <= wdata;
					else code[(addr - DEV_MB_BASE) >> MB_SHIFT] <= wdata[27:24];
					n_bad <= n_bad + int'(!freeze_enable);
				end
			end
		end
	end
endmodule : cbti_dev_model
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import cbti_pkg::*;
	localparam int NB = 4;
	localparam int PR = 2;
	logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, lp = 1'b0;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, dreq, dwe, dack;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'hf, dly = 4'h0;
	logic [11:0] daddr;
	logic [31:0] wdat = '0, rdat, dwd, drd;
	int          n_errors = 0, n_tests = 0, n_run = 0;
	always #4 clk = ~clk;
	cbti_host #(.NUM_BUF(NB), .PCLK_OVER_OSC(PR)) cbti_host_inst (
		.CLK_SYS(clk), .SYS_RST(rst), .CE(ce), .LOW_POWER(lp),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.DEV_REQ(dreq), .DEV_WE(dwe), .DEV_ADDR(daddr), .DEV_WDATA(dwd),
		.DEV_RDATA(drd), .DEV_ACK(dack));
	cbti_dev_model #(.NUM_BUF(NB)) cbti_dev_model_inst (
		.clk(clk), .rst(rst), .req(dreq), .we(dwe), .addr(daddr),
		.wdata(dwd), .dly(dly), .ack(dack), .rdata(drd));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 100);
		if (n >= 100) begin
			n_errors++;
			conclude();
		end
		q = rdat;
		{cyc, stb} <= 2'b00;
		@(posedge clk);
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask : wr
	function automatic logic [5:0] flt(input logic [31:0] t, input logic l);
		int s1, s2, rj, nq, mn;
		s1 = int'(t[CTRL_PROP+:3]) + int'(t[CTRL_P1+:3]) + 2;
		s2 = int'(t[CTRL_P2+:3]) + 1;
		rj = int'(t[CTRL_RJW+:2]) + 1;
		nq = 1 + s1 + s2;
		mn = s2 == 2 ? 5 : s2 == 3 ? 4 : s2 + 1;
		flt[0] = s1 < 4 || s1 > 16;
		flt[1] = s2 < 2 || s2 > 8;
		flt[2] = s1 < mn || s1 > s2 + 8 || rj > s2 || rj > 4;
		flt[3] = nq < 8;
		flt[4] = (int'(t[CTRL_PRES+:8]) + 1) * nq * (t[CTRL_CSRC] ? PR : 1) < 16;
		flt[5] = l;
	endfunction : flt
	task automatic run(input logic [1:0] c, input logic [31:0] t, m, b);
		logic [31:0] q;
		logic [5:0]  f;
		int          n0, k;
		n0 = cbti_dev_model_inst.n_acc;
		dly <= 4'($urandom % 8);
		wr(TIM_OFF, t);
		// low-power level may be set by the caller in the same time step
		f = flt(t, lp && c[1]);
		wr(MASK_OFF, m);
		wr(BACT_OFF, b);
		wr(CMD_OFF, {30'h0, c});
		// settings are locked while a run is going
		if (f == 6'h0) wr(TIM_OFF, ~t);
		k = 0;
		do begin
			wb(1'b0, STAT_OFF, 32'h0, q);
			k++;
		end while (q[ST_BUSY] !== 1'b0 && k < 500);
		if (k >= 500) begin
			n_errors++;
			conclude();
		end
		chk(q & 32'h000f3f07, {12'h0, f != 0 ? S_FAIL : S_DONE, 2'b00, f, 5'h0,
			f != 0, f == 0, 1'b0});
		if (f != 6'h0) chk(cbti_dev_model_inst.n_acc, n0);
		else begin
			chk(cbti_dev_model_inst.ctrl, t);
			chk(cbti_dev_model_inst.buffer_interrupt_mask, m & 32'hf);
			for (int i = 0; i < NB; i++)
				chk(32'(cbti_dev_model_inst.code[i]),
					b[i] ? 32'h4 : 32'h0);
			chk(cbti_dev_model_inst.n_bad, 0);
			wb(1'b0, TIM_OFF, 32'h0, q);
			chk(q, t);
		end
		n_run++;
		$display("test %0d done, cmd %h timing %h", n_run, c, t);
	endtask : run
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	initial begin
		#400000;
		n_errors++;
		conclude();
	end
	initial begin
		logic [31:0] q;
		logic [7:0]  ra [6];
		logic [31:0] ct [8];
		ra = '{TIM_OFF, MASK_OFF, BACT_OFF, CMD_OFF, 8'h14, 8'hfc};
		// quanta and ratio edges, table limits, source bit, short segments
		ct = '{32'h01010003, 32'h00012003, 32'h00010003, 32'h00ff0017,
			32'h01290004, 32'h01810003, 32'h00030000, 32'h01000005};
		void'($urandom(34422));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		wr(8'h14, 32'hffffffff);
		foreach (ra[i]) begin
			wb(1'b0, ra[i], 32'h0, q);
			chk(q, 32'h0);
		end
		$display("test reset values done");
		sel <= 4'h3;
		wr(TIM_OFF, 32'ha5a5a5a5);
		sel <= 4'hf;
		wb(1'b0, TIM_OFF, 32'h0, q);
		chk(q, 32'h0000a5a5);
		$display("test byte lanes done");
		foreach (ct[i])
			run(2'b01, ct[i], $urandom, $urandom);
		run(2'b11, 32'h01010013, $urandom, $urandom);
		lp <= 1'b1;
		run(2'b11, 32'h01010003, $urandom, $urandom);
		lp <= 1'b0;
		repeat (24) run({1'($urandom), 1'b1}, $urandom & 32'h03ff2017,
			$urandom, $urandom);
		conclude();
	end
endmodule : tb_top
`default_nettype wire
